// File: inc/eru_channel_pkg.sv
// Package with constants for the event request input channel
`default_nettype none
package eru_channel_pkg;
    // Source selector width (four sources)
    localparam int unsigned SEL_W          = 2;
    // Filter depth and divider field widths
    localparam int unsigned DEPTH_W        = 4;
    localparam int unsigned DIV_W          = 4;
    // Reset values of the control settings
    localparam logic [1:0]  SEL_RESET      = 2'h0;
    localparam logic        EDGE_EN_RESET  = 1'b0;
    localparam logic        FILT_EN_RESET  = 1'b0;
    localparam logic [3:0]  DEPTH_RESET    = 4'h0;
    localparam logic [3:0]  DIV_RESET      = 4'h0;
    // Output routing: one of eight output stages
    localparam int unsigned ROUTE_W        = 3;
    localparam logic [2:0]  ROUTE_RESET    = 3'h0;
endpackage : eru_channel_pkg
`default_nettype wire

// File: hdl/eru_input_filter.sv
// Digital input filter clocked by a divided peripheral bus clock
`default_nettype none
module eru_input_filter
#(
    parameter int unsigned DEPTH_W = 4,
    parameter int unsigned DIV_W   = 4
)
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               filt_en,
    input  wire logic [DEPTH_W-1:0] depth,
    input  wire logic [DIV_W-1:0]   div,
    input  wire logic               raw_in,
    output logic                    filt_out
);
    logic [DIV_W-1:0]   div_cnt;
    logic [DEPTH_W-1:0] stable_cnt;
    logic               tick;

    // Divider tick every div+1 cycles
    assign tick = (div_cnt == div);

    always_ff @(posedge clk)
    begin
        if (sys_rst || tick)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // Output follows input once stable for depth ticks, or directly when off
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stable_cnt <= '0;
            filt_out   <= 1'b0;
        end
        else if (!filt_en || depth == '0)
        begin
            stable_cnt <= '0;
            filt_out   <= raw_in;
        end
        else if (raw_in == filt_out)
            stable_cnt <= '0;
        else if (tick)
        begin
            if (stable_cnt + 1'b1 >= depth)
            begin
                filt_out   <= raw_in;
                stable_cnt <= '0;
            end
            else
                stable_cnt <= stable_cnt + 1'b1;
        end
    end
endmodule : eru_input_filter
`default_nettype wire

// File: hdl/event_request_input_channel.sv
// Input channel of the event request unit: select, filter, edge detect, flag
// Operation
// - A change of the control settings alone can make the edge detector see an event.
// - Switching the selector from a high source to a low source with falling enable set flags and forwards an edge.
// - With both edge enables clear, any edge arriving at detection is discarded.
// - A filtered edge takes depth times (divider plus one) cycles to reach detection; software waits that long.
`default_nettype none
module event_request_input_channel
    import eru_channel_pkg::*;
#(
    parameter int unsigned N_SRC = 4
)
(
    input  wire logic                                 clk,
    input  wire logic                                 sys_rst,
    input  wire logic [N_SRC-1:0]                     src_in,
    input  wire logic                                 ctrl_wr,
    input  wire logic [eru_channel_pkg::SEL_W-1:0]    input_source_select,
    input  wire logic                                 rising_edge_enable,
    input  wire logic                                 falling_edge_enable,
    input  wire logic [eru_channel_pkg::ROUTE_W-1:0]  route_sel,
    input  wire logic                                 filt_wr,
    input  wire logic                                 filter_enable,
    input  wire logic [eru_channel_pkg::DEPTH_W-1:0]  filter_depth,
    input  wire logic [eru_channel_pkg::DIV_W-1:0]    filter_clock_divider,
    input  wire logic                                 flag_clear,
    output logic                                      channel_event_flag,
    output logic [7:0]                                trigger_out,
    output logic                                      level_out
);
    import eru_channel_pkg::*;

    logic [SEL_W-1:0]   sel;
    logic               ren;
    logic               fen;
    logic [ROUTE_W-1:0] route;
    logic               f_en;
    logic [DEPTH_W-1:0] f_depth;
    logic [DIV_W-1:0]   f_div;
    logic               raw_level;
    logic               filt_level;
    logic               prev_level;
    logic               rise;
    logic               fall;
    logic               edge_hit;

    // Input channel control register, rewritten whole on each write
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sel   <= SEL_RESET;
            ren   <= EDGE_EN_RESET;
            fen   <= EDGE_EN_RESET;
            route <= ROUTE_RESET;
        end
        else if (ctrl_wr)
        begin
            sel   <= input_source_select;
            ren   <= rising_edge_enable;
            fen   <= falling_edge_enable;
            route <= route_sel;
        end
    end

    // Input filter control register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            f_en    <= FILT_EN_RESET;
            f_depth <= DEPTH_RESET;
            f_div   <= DIV_RESET;
        end
        else if (filt_wr)
        begin
            f_en    <= filter_enable;
            f_depth <= filter_depth;
            f_div   <= filter_clock_divider;
        end
    end

    // Source multiplexer; a selector change is seen as a level change
    assign raw_level = src_in[sel];

    eru_input_filter
    #(
        .DEPTH_W (DEPTH_W),
        .DIV_W   (DIV_W)
    )
    u_filter
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .filt_en  (f_en),
        .depth    (f_depth),
        .div      (f_div),
        .raw_in   (raw_level),
        .filt_out (filt_level)
    );

    // Previous sampled level, updated every cycle regardless of enables
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prev_level <= 1'b0;
        else
            prev_level <= filt_level;
    end

    // Edge detection gated by the enables; disabled edges are swallowed
    assign rise     = filt_level & ~prev_level & ren;
    assign fall     = ~filt_level & prev_level & fen;
    assign edge_hit = rise | fall;

    // Sticky event flag; a new edge wins over a clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            channel_event_flag <= 1'b0;
        else if (edge_hit)
            channel_event_flag <= 1'b1;
        else if (flag_clear)
            channel_event_flag <= 1'b0;
    end

    // One-cycle trigger to the configured output stage
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            trigger_out <= 8'h00;
        else
            trigger_out <= edge_hit ? (8'h01 << route) : 8'h00;
    end

    // Registered filtered level for status
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            level_out <= 1'b0;
        else
            level_out <= filt_level;
    end
endmodule : event_request_input_channel
`default_nettype wire

// File: sim/event_request_input_channel_asserts.sv
// Assertions on the event request input channel ports
`default_nettype none
module event_request_input_channel_asserts
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       ctrl_wr,
    input wire logic       rising_edge_enable,
    input wire logic       falling_edge_enable,
    input wire logic [2:0] route_sel,
    input wire logic       flag_clear,
    input wire logic       channel_event_flag,
    input wire logic [7:0] trigger_out,
    input wire logic       level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       ren_q;
    logic       fen_q;
    logic [2:0] route_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Shadow of the enables and route as the channel holds them
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ren_q   <= 1'b0;
            fen_q   <= 1'b0;
            route_q <= 3'h0;
        end
        else if (ctrl_wr)
        begin
            ren_q   <= rising_edge_enable;
            fen_q   <= falling_edge_enable;
            route_q <= route_sel;
        end
    end
    // The trigger pulse stands in the same cycle as the registered level move
    property p_fall;
        $fell(level_out) && $past(fen_q) |-> trigger_out == (8'h01 << $past(route_q));
    endproperty
    a_fall: assert property (p_fall) else $error("falling level not forwarded");
    property p_rise;
        $rose(level_out) && $past(ren_q) |-> trigger_out == (8'h01 << $past(route_q));
    endproperty
    a_rise: assert property (p_rise) else $error("rising level not forwarded");
    property p_quiet;
        (!ren_q && !fen_q)[*2] |-> trigger_out == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("trigger with edges disabled");
    property p_noflag;
        !ren_q && !fen_q && !channel_event_flag |=> !channel_event_flag;
    endproperty
    a_noflag: assert property (p_noflag) else $error("flag set with edges disabled");
    property p_hold;
        channel_event_flag && !flag_clear |=> channel_event_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("event flag dropped");
    c_trig: cover property (trigger_out != 8'h00);
    c_clear: cover property (channel_event_flag && flag_clear);
    c_fall: cover property ($fell(level_out) && fen_q);
endmodule // event_request_input_channel_asserts
`default_nettype wire

// File: sim/event_request_input_channel_tb.sv
// Testbench for the event request input channel
`default_nettype none
module event_request_input_channel_tb;
    import eru_channel_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0, filt_wr = 1'b0, flag_clear = 1'b0;
    logic       rising_edge_enable = 1'b0, falling_edge_enable = 1'b0, filter_enable = 1'b0;
    logic [3:0] src_in = 4'b1010, filter_depth = 4'h0, filter_clock_divider = 4'h0;
    logic [1:0] input_source_select = 2'h0;
    logic [2:0] route_sel = 3'h5;
    logic [7:0] trigger_out, seen;
    logic       channel_event_flag, level_out;
    logic       flag_seen = 1'b0, lvl_seen = 1'b0;
    int         errors = 0, n_checks = 0;
    always #50 clk = ~clk;
    event_request_input_channel u_event_request_input_channel (.clk, .sys_rst, .src_in, .ctrl_wr,
        .input_source_select, .rising_edge_enable, .falling_edge_enable, .route_sel, .filt_wr,
        .filter_enable, .filter_depth, .filter_clock_divider, .flag_clear, .channel_event_flag,
        .trigger_out, .level_out);
    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One control write, then gather triggers over n cycles
    task automatic ctrl(input logic [1:0] s, input logic r, input logic f, input int n);
        ctrl_wr <= 1'b1;
        input_source_select <= s;
        rising_edge_enable <= r;
        falling_edge_enable <= f;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        seen = 8'h00;
        // Outputs are read at the falling edge, where they have settled
        repeat (n)
        begin
            @(negedge clk);
            seen      = seen | trigger_out;
            flag_seen = channel_event_flag;
            lvl_seen  = level_out;
        end
        @(posedge clk);
    endtask
    task automatic clr();
        flag_clear <= 1'b1;
        @(posedge clk);
        flag_clear <= 1'b0;
        @(posedge clk);
    endtask
    // Selector moves alone make edges, gated per direction
    task automatic t_switch();
        ctrl(2'h1, 1'b0, 1'b0, 4);
        check({7'h0, flag_seen}, 8'h00);
        ctrl(2'h0, 1'b0, 1'b1, 4);
        check(seen, 8'h20);
        check({7'h0, flag_seen}, 8'h01);
        clr();
        ctrl(2'h1, 1'b0, 1'b1, 4);
        check(seen, 8'h00);
        ctrl(2'h0, 1'b1, 1'b0, 4);
        check(seen, 8'h00);
        ctrl(2'h1, 1'b1, 1'b0, 4);
        check(seen, 8'h20);
    endtask
    // Three-write reconfiguration swallows the switch edge
    task automatic t_safe();
        clr();
        ctrl(2'h1, 1'b0, 1'b0, 2);
        ctrl(2'h2, 1'b0, 1'b0, 4);
        check(seen, 8'h00);
        ctrl(2'h2, 1'b1, 1'b1, 4);
        check(seen, 8'h00);
        check({7'h0, flag_seen}, 8'h00);
    endtask
    // Filtered edge arrives late and is swallowed during the wait
    task automatic t_filter();
        filt_wr <= 1'b1;
        filter_enable <= 1'b1;
        filter_depth <= 4'h3;
        filter_clock_divider <= 4'h1;
        @(posedge clk);
        filt_wr <= 1'b0;
        ctrl(2'h2, 1'b0, 1'b0, 2);
        ctrl(2'h3, 1'b0, 1'b0, 2);
        check({7'h0, lvl_seen}, 8'h00);
        repeat (6) @(posedge clk);
        ctrl(2'h3, 1'b1, 1'b1, 4);
        check(seen, 8'h00);
        check({7'h0, lvl_seen}, 8'h01);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_switch();
        t_safe();
        t_filter();
        wrap_up();
    end
endmodule // event_request_input_channel_tb
bind event_request_input_channel event_request_input_channel_asserts u_chk (.clk, .sys_rst, .ctrl_wr,
    .rising_edge_enable, .falling_edge_enable, .route_sel, .flag_clear, .channel_event_flag,
    .trigger_out, .level_out);
`default_nettype wire
